// *** hw/tss_pkg.sv ***
// Package with register map, field positions and timing constants for the supervisor.
package tss_pkg;

    // ************************************************************
    // Register offsets (byte addresses, one 32-bit word each)
    // ************************************************************
    localparam logic [3:0] TSS_OFF_CTRL   = 4'h0;
    localparam logic [3:0] TSS_OFF_STATUS = 4'h4;
    localparam logic [3:0] TSS_OFF_IRQ    = 4'h8;
    localparam logic [3:0] TSS_OFF_MASK   = 4'hC;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int TSS_CTRL_LIMIT_SEL = 0;
    localparam int TSS_CTRL_LOW_SUP   = 1;
    localparam int TSS_CTRL_FAILSAFE  = 2;
    localparam int TSS_CTRL_SLOPE_LSB = 3;
    localparam int TSS_CTRL_CHOPPER_OFF_TIME_LSB  = 5;
    localparam int TSS_CTRL_SCALE_LSB = 9;
    localparam logic [31:0] TSS_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TSS_CTRL_WMASK = 32'h0000_3FFF;

    // ************************************************************
    // Status register fields
    // ************************************************************
    localparam int TSS_ST_WARN      = 0;
    localparam int TSS_ST_SHUT      = 1;
    localparam int TSS_ST_STILL     = 2;
    localparam int TSS_ST_EXT_CLK   = 3;
    localparam int TSS_ST_CLK_FAIL  = 4;
    localparam int TSS_ST_DRV_EN    = 5;
    localparam int TSS_ST_SCALE_LSB = 8;

    // ************************************************************
    // Interrupt status bits
    // ************************************************************
    localparam int TSS_IRQ_WARN  = 0;
    localparam int TSS_IRQ_SHUT  = 1;
    localparam int TSS_IRQ_STILL = 2;
    localparam int TSS_IRQ_FAIL  = 3;
    localparam int TSS_IRQ_W     = 4;

    // ************************************************************
    // Slope modes with temperature compensation (codes 2 and 3)
    // ************************************************************
    localparam logic [1:0] TSS_SLOPE_COMP_MIN = 2'h2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int TSS_STILL_CYCLES = 1048576;  // Two to the twentieth clocks.
    localparam int TSS_FAIL_MIN     = 32;
    localparam int TSS_FAIL_MAX     = 48;
    localparam int TSS_FAIL_CYCLES  = 40;       // Inside the 32 to 48 window.
    localparam int TSS_FAIL_W       = 6;

endpackage

// *** hw/tss_sync.sv ***
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/10ps
module tss_sync
    import tss_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Data
    input  wire logic d,
    output logic      q
);
    logic meta_reg;
    logic meta_next;
    logic q_next;

    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            q        <= q_next;
        end
    end
endmodule

// *** hw/tss_clk_monitor.sv ***
// External clock detection and fail-safe fallback monitor.
`timescale 1ns/10ps
module tss_clk_monitor
    import tss_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // Control
    input  wire logic failsafe_en,
    // Synchronised external clock level
    input  wire logic ext_clk_s,
    // Status
    output logic      ext_sel,
    output logic      logic_run,
    output logic      fail_pulse
);
    logic                  prev_reg;
    logic                  prev_next;
    logic                  sel_next;
    logic                  run_next;
    logic                  fail_next;
    logic [TSS_FAIL_W-1:0] cnt_reg;
    logic [TSS_FAIL_W-1:0] cnt_next;
    logic                  edge_seen;

    always_comb begin
        edge_seen = ext_clk_s != prev_reg;
        prev_next = ext_clk_s;
        sel_next  = ext_sel;
        run_next  = logic_run;
        cnt_next  = cnt_reg;
        fail_next = 1'b0;
        if (!ext_sel) begin
            run_next = 1'b1;
            cnt_next = '0;
            if (ext_clk_s) begin
                sel_next = 1'b1;
            end
        end else if (edge_seen) begin
            cnt_next = '0;
            run_next = 1'b1;
        end else if (cnt_reg != TSS_FAIL_W'(TSS_FAIL_CYCLES)) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (failsafe_en) begin
            sel_next  = 1'b0;
            fail_next = 1'b1;
            cnt_next  = '0;
        end else begin
            run_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg   <= 1'b0;
            ext_sel    <= 1'b0;
            logic_run  <= 1'b1;
            cnt_reg    <= '0;
            fail_pulse <= 1'b0;
        end else if (ce) begin
            prev_reg   <= prev_next;
            ext_sel    <= sel_next;
            logic_run  <= run_next;
            cnt_reg    <= cnt_next;
            fail_pulse <= fail_next;
        end
    end
endmodule

// *** hw/tss_supervisor.sv ***
// Thermal, supply and clock supervisor with Avalon-MM register access.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module tss_supervisor
    import tss_pkg::*;
#(
    parameter int STILL_CYCLES = TSS_STILL_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // Supply monitor and detector pins
    input  wire logic        undervoltage_b,
    input  wire logic        temp_ge_warn,
    input  wire logic        temp_ge_release,
    input  wire logic        temp_ge_reduced,
    input  wire logic        temp_ge_high,
    input  wire logic        driver_disable_pin,
    input  wire logic        ext_clk_level,
    input  wire logic        step_pulse,
    input  wire logic        high_side_short,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Driver controls
    output logic             driver_enable,
    output logic [2:0]       gate_current_step,
    output logic             uv_level_low,
    output logic             resonance_damp_en,
    output logic             low_side_detect_en,
    output logic             short_sense_high,
    output logic             high_side_short_off,
    output logic             ext_clk_selected,
    output logic             irq
);
    // ************************************************************
    // Reset and pin synchronisation
    // ************************************************************
    // Undervoltage is just another source of the asynchronous reset.
    logic rst_int_b;
    assign rst_int_b = rst_b & undervoltage_b;

    logic warn_s;
    logic rel_s;
    logic red_s;
    logic high_s;
    logic dis_s;
    logic ext_s;
    logic step_s;

    tss_sync u_s_warn (.clk(clk), .rst_b(rst_int_b), .d(temp_ge_warn),       .q(warn_s));
    tss_sync u_s_rel  (.clk(clk), .rst_b(rst_int_b), .d(temp_ge_release),    .q(rel_s));
    tss_sync u_s_red  (.clk(clk), .rst_b(rst_int_b), .d(temp_ge_reduced),    .q(red_s));
    tss_sync u_s_high (.clk(clk), .rst_b(rst_int_b), .d(temp_ge_high),       .q(high_s));
    tss_sync u_s_dis  (.clk(clk), .rst_b(rst_int_b), .d(driver_disable_pin), .q(dis_s));
    tss_sync u_s_ext  (.clk(clk), .rst_b(rst_int_b), .d(ext_clk_level),      .q(ext_s));
    tss_sync u_s_step (.clk(clk), .rst_b(rst_int_b), .d(step_pulse),         .q(step_s));

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0]         ctrl_reg;
    logic [31:0]         ctrl_next;
    logic [TSS_IRQ_W-1:0] irq_reg;
    logic [TSS_IRQ_W-1:0] irq_next;
    logic [TSS_IRQ_W-1:0] mask_reg;
    logic [TSS_IRQ_W-1:0] mask_next;
    logic [31:0]         rdata_next;
    logic                shut_reg;
    logic                shut_next;
    logic [20:0]         still_cnt_reg;
    logic [20:0]         still_cnt_next;
    logic                still_reg;
    logic                still_next;
    logic                step_prev_reg;
    logic                warn_prev_reg;
    logic                shut_prev_reg;
    logic                still_prev_reg;
    logic                rd_ack_reg;
    logic                rd_ack_next;

    logic       limit_sel;
    logic       failsafe_en;
    logic [1:0] slope_mode;
    logic [3:0] off_time;
    logic [4:0] cur_scale;
    logic       over_limit;
    logic       logic_run;
    logic       fail_pulse;
    logic       ext_sel;
    logic       run_ce;
    logic       wr_hit;
    logic       rd_hit;
    logic [TSS_IRQ_W-1:0] events;

    assign limit_sel   = ctrl_reg[TSS_CTRL_LIMIT_SEL];
    assign failsafe_en = ctrl_reg[TSS_CTRL_FAILSAFE];
    assign slope_mode  = ctrl_reg[TSS_CTRL_SLOPE_LSB +: 2];
    assign off_time    = ctrl_reg[TSS_CTRL_CHOPPER_OFF_TIME_LSB +: 4];
    assign cur_scale   = ctrl_reg[TSS_CTRL_SCALE_LSB +: 5];

    // A stopped external clock with fail-safe off freezes the logic.
    assign run_ce = ce & logic_run;

    tss_clk_monitor u_clkmon (
        .clk         (clk),
        .rst_b       (rst_int_b),
        .ce          (ce),
        .failsafe_en (failsafe_en),
        .ext_clk_s   (ext_s),
        .ext_sel     (ext_sel),
        .logic_run   (logic_run),
        .fail_pulse  (fail_pulse)
    );

    // Applies byte enables to a write of a 32-bit word.
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // Thermal and standstill logic
    // ************************************************************
    always_comb begin
        over_limit = limit_sel ? red_s : high_s;
        shut_next  = shut_reg;
        if (over_limit) begin
            shut_next = 1'b1;
        end else if (!rel_s) begin
            shut_next = 1'b0;
        end
        still_cnt_next = still_cnt_reg;
        still_next     = still_reg;
        if (step_s && !step_prev_reg) begin
            still_cnt_next = '0;
            still_next     = 1'b0;
        end else if (still_cnt_reg != 21'(STILL_CYCLES)) begin
            still_cnt_next = still_cnt_reg + 21'h00_0001;
        end else begin
            still_next = 1'b1;
        end
    end

    // ************************************************************
    // Bus and interrupt registers
    // ************************************************************
    // One wait state per read lets the registered data stand when waitrequest drops.
    assign avs_waitrequest = avs_read & ~rd_ack_reg;
    assign wr_hit = avs_write;
    assign rd_hit = avs_read & ~rd_ack_reg;

    assign events = {fail_pulse, still_reg & ~still_prev_reg,
                     shut_reg & ~shut_prev_reg, warn_s & ~warn_prev_reg};

    always_comb begin
        ctrl_next  = ctrl_reg;
        mask_next  = mask_reg;
        irq_next   = irq_reg;
        rdata_next = 32'h0000_0000;
        rd_ack_next = rd_hit;
        if (wr_hit) begin
            case (avs_address)
                TSS_OFF_CTRL: begin
                    ctrl_next = be_merge(ctrl_reg, avs_writedata, avs_byteenable)
                                & TSS_CTRL_WMASK;
                end
                TSS_OFF_IRQ: begin
                    if (avs_byteenable[0]) begin
                        irq_next = irq_reg & ~avs_writedata[TSS_IRQ_W-1:0];
                    end
                end
                TSS_OFF_MASK: begin
                    if (avs_byteenable[0]) begin
                        mask_next = avs_writedata[TSS_IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // New events win over a clear in the same cycle.
        irq_next = irq_next | events;
        if (rd_hit) begin
            case (avs_address)
                TSS_OFF_CTRL:   rdata_next = ctrl_reg;
                TSS_OFF_STATUS: begin
                    rdata_next[TSS_ST_WARN]     = warn_s;
                    rdata_next[TSS_ST_SHUT]     = shut_reg;
                    rdata_next[TSS_ST_STILL]    = still_reg;
                    rdata_next[TSS_ST_EXT_CLK]  = ext_sel;
                    rdata_next[TSS_ST_CLK_FAIL] = irq_reg[TSS_IRQ_FAIL];
                    rdata_next[TSS_ST_DRV_EN]   = driver_enable;
                    rdata_next[TSS_ST_SCALE_LSB +: 5] = cur_scale;
                end
                TSS_OFF_IRQ:    rdata_next[TSS_IRQ_W-1:0] = irq_reg;
                TSS_OFF_MASK:   rdata_next[TSS_IRQ_W-1:0] = mask_reg;
                default:        rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            ctrl_reg       <= TSS_CTRL_RESET;
            mask_reg       <= '0;
            irq_reg        <= '0;
            avs_readdata   <= 32'h0000_0000;
            shut_reg       <= 1'b0;
            still_cnt_reg  <= '0;
            still_reg      <= 1'b0;
            step_prev_reg  <= 1'b0;
            warn_prev_reg  <= 1'b0;
            shut_prev_reg  <= 1'b0;
            still_prev_reg <= 1'b0;
            rd_ack_reg     <= 1'b0;
        end else if (run_ce) begin
            ctrl_reg       <= ctrl_next;
            mask_reg       <= mask_next;
            irq_reg        <= irq_next;
            avs_readdata   <= rdata_next;
            shut_reg       <= shut_next;
            still_cnt_reg  <= still_cnt_next;
            still_reg      <= still_next;
            step_prev_reg  <= step_s;
            warn_prev_reg  <= warn_s;
            shut_prev_reg  <= shut_reg;
            still_prev_reg <= still_reg;
            rd_ack_reg     <= rd_ack_next;
        end
    end

    // ************************************************************
    // Driver outputs
    // ************************************************************
    // The driver is also off while the logic is frozen by a lost clock.
    assign driver_enable = rst_int_b & logic_run & ~shut_reg
                           & ~dis_s & (off_time != 4'h0);
    assign gate_current_step = {1'b0, slope_mode}
                               + ((slope_mode >= TSS_SLOPE_COMP_MIN && warn_s)
                                  ? 3'h1 : 3'h0);
    assign uv_level_low       = ctrl_reg[TSS_CTRL_LOW_SUP];
    assign resonance_damp_en  = ctrl_reg[TSS_CTRL_LOW_SUP];
    assign low_side_detect_en = failsafe_en;
    assign short_sense_high   = failsafe_en;
    // The short detector is combinational so it acts with no clock.
    assign high_side_short_off = high_side_short;
    assign ext_clk_selected   = ext_sel;
    assign irq = |(irq_reg & mask_reg);
endmodule

// *** testbench/tss_env_model.sv ***
// Environment model: temperature detector levels and the external clock source.
`timescale 1ns/10ps
module tss_env_model (
    // Clock and scenario controls
    input  wire logic       clk,
    input  wire logic [7:0] temp_c,
    input  wire logic       ext_run,
    // Detector levels and clock pin
    output logic            temp_ge_warn,
    output logic            temp_ge_release,
    output logic            temp_ge_reduced,
    output logic            temp_ge_high,
    output logic            ext_clk_level
);
    logic [1:0] phase_reg;

    assign temp_ge_warn    = temp_c >= 8'h64;
    assign temp_ge_release = temp_c >= 8'h78;
    assign temp_ge_reduced = temp_c >= 8'h88;
    assign temp_ge_high    = temp_c >= 8'h96;
    // A stopped source leaves the pin at its pull-down level, never parked high.
    assign ext_clk_level   = phase_reg[1];

    always_ff @(posedge clk) begin
        phase_reg <= ext_run ? phase_reg + 2'h1 : 2'h0;
    end
endmodule

// *** testbench/tss_supervisor_sva.sv ***
// Port-level assertions for the supervisor, bound to its top module.
`timescale 1ns/10ps
module tss_sva
    import tss_pkg::*;
#(
    parameter int STILL_CYCLES = TSS_STILL_CYCLES
)
(
    // Clock, reset and inputs
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        undervoltage_b,
    input wire logic        temp_ge_release,
    input wire logic        temp_ge_high,
    input wire logic        driver_disable_pin,
    input wire logic        ext_clk_level,
    input wire logic        high_side_short,
    // Outputs under watch
    input wire logic [31:0] avs_readdata,
    input wire logic        driver_enable,
    input wire logic [2:0]  gate_current_step,
    input wire logic        uv_level_low,
    input wire logic        resonance_damp_en,
    input wire logic        low_side_detect_en,
    input wire logic        short_sense_high,
    input wire logic        high_side_short_off,
    input wire logic        ext_clk_selected,
    input wire logic        irq
);
    // Slack covers the two synchroniser stages and the selection register.
    localparam int FAIL_HI = TSS_FAIL_MAX + 6;

    logic [7:0] since_high_reg;
    logic [7:0] since_high_next;

    always_comb begin
        since_high_next = since_high_reg;
        if (ext_clk_level)
            since_high_next = 8'h00;
        else if (since_high_reg != 8'hFF)
            since_high_next = since_high_reg + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            since_high_reg <= 8'hFF;
        else
            since_high_reg <= since_high_next;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence hot_s;
        temp_ge_high [*4];
    endsequence
    sequence cool_s;
        (temp_ge_release && !temp_ge_high) [*3];
    endsequence

    hs_short_a: assert property (high_side_short_off == high_side_short)
        else $error("short cut-off does not follow its detector");
    pin_frees_a: assert property (driver_disable_pin [*4] |-> !driver_enable)
        else $error("driver enabled while the disable pin is high");
    uv_pair_a: assert property (uv_level_low == resonance_damp_en)
        else $error("trip level and dampening disagree");
    fs_pair_a: assert property (low_side_detect_en == short_sense_high)
        else $error("low-side detector and sensitivity disagree");
    shut_off_a: assert property (hot_s |-> !driver_enable)
        else $error("driver enabled above the shutdown level");
    hold_off_a: assert property (hot_s ##1 cool_s |-> !driver_enable)
        else $error("driver re-enabled above the release level");
    uv_clear_a: assert property (!undervoltage_b |-> !driver_enable && !irq &&
        !ext_clk_selected && gate_current_step == 3'h0)
        else $error("outputs not cleared in undervoltage");
    uv_read_a: assert property (!undervoltage_b |-> avs_readdata == 32'h0)
        else $error("read data not cleared in undervoltage");
    ext_sel_a: assert property ($rose(ext_clk_selected) |-> since_high_reg <= 8'h04)
        else $error("external clock selected without a high level");
    fail_bound_a: assert property (low_side_detect_en && ext_clk_selected |->
        since_high_reg <= FAIL_HI)
        else $error("fallback to internal clock too late");
    fail_early_a: assert property ($fell(ext_clk_selected) && undervoltage_b |->
        since_high_reg >= TSS_FAIL_MIN)
        else $error("fallback to internal clock too early");
endmodule

bind tss_supervisor tss_sva #(.STILL_CYCLES(STILL_CYCLES)) sva_u (
    .clk(clk), .rst_b(rst_b), .undervoltage_b(undervoltage_b),
    .temp_ge_release(temp_ge_release), .temp_ge_high(temp_ge_high),
    .driver_disable_pin(driver_disable_pin), .ext_clk_level(ext_clk_level),
    .high_side_short(high_side_short), .avs_readdata(avs_readdata),
    .driver_enable(driver_enable), .gate_current_step(gate_current_step),
    .uv_level_low(uv_level_low), .resonance_damp_en(resonance_damp_en),
    .low_side_detect_en(low_side_detect_en), .short_sense_high(short_sense_high),
    .high_side_short_off(high_side_short_off), .ext_clk_selected(ext_clk_selected),
    .irq(irq));

// *** testbench/testbench.sv ***
// Self-checking bench: register tasks with thermal, supply and clock scenarios.
`timescale 1ns/10ps
module testbench
    import tss_pkg::*;
;
    logic clk, rst_b, ce, undervoltage_b, driver_disable_pin, step_pulse, high_side_short;
    logic t_warn, t_rel, t_red, t_high, ext_clk_level;
    logic [3:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [3:0]  avs_byteenable;
    logic        driver_enable, uv_level_low, resonance_damp_en, low_side_detect_en;
    logic        short_sense_high, high_side_short_off, ext_clk_selected, irq;
    logic [2:0]  gate_current_step;
    logic [7:0]  temp_c;
    logic        ext_run;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    tss_supervisor #(.STILL_CYCLES(20)) dut_u (
        .clk(clk), .rst_b(rst_b), .ce(ce), .undervoltage_b(undervoltage_b),
        .temp_ge_warn(t_warn), .temp_ge_release(t_rel), .temp_ge_reduced(t_red),
        .temp_ge_high(t_high), .driver_disable_pin(driver_disable_pin),
        .ext_clk_level(ext_clk_level), .step_pulse(step_pulse),
        .high_side_short(high_side_short), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .driver_enable(driver_enable),
        .gate_current_step(gate_current_step), .uv_level_low(uv_level_low),
        .resonance_damp_en(resonance_damp_en), .low_side_detect_en(low_side_detect_en),
        .short_sense_high(short_sense_high), .high_side_short_off(high_side_short_off),
        .ext_clk_selected(ext_clk_selected), .irq(irq));

    tss_env_model env_u (
        .clk(clk), .temp_c(temp_c), .ext_run(ext_run), .temp_ge_warn(t_warn),
        .temp_ge_release(t_rel), .temp_ge_reduced(t_red), .temp_ge_high(t_high),
        .ext_clk_level(ext_clk_level));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stands at the edge where waitrequest is seen low, so it is taken there.
    task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        chk(rdata & m, e);
        @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst_b, driver_disable_pin, step_pulse, high_side_short, avs_read, avs_write} = '0;
        {ce, undervoltage_b} = 2'h3;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        temp_c = 8'h19;
        ext_run = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        cyc(2);
        rdchk(TSS_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
        rdchk(TSS_OFF_STATUS, 32'h1F23, 32'h0);
        rdchk(TSS_OFF_MASK, 32'hFFFF_FFFF, 32'h0);
        wr(4'h6, 32'hFFFF_FFFF);
        rdchk(4'h6, 32'hFFFF_FFFF, 32'h0);
        rdchk(TSS_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
        high_side_short <= 1'b1;
        cyc(1);
        chk(high_side_short_off, 32'h1);
        high_side_short <= 1'b0;
        wr(TSS_OFF_CTRL, 32'h0000_0026);
        cyc(4);
        chk({uv_level_low, resonance_damp_en, low_side_detect_en, short_sense_high}, 32'hF);
        chk(driver_enable, 32'h1);
        driver_disable_pin <= 1'b1;
        cyc(4);
        chk(driver_enable, 32'h0);
        driver_disable_pin <= 1'b0;
        wr(TSS_OFF_CTRL, 32'h0000_0000);
        cyc(2);
        chk(driver_enable, 32'h0);
        wr(TSS_OFF_CTRL, 32'h0000_0030);
        wr(TSS_OFF_MASK, 32'h0);
        temp_c <= 8'h6E;
        cyc(6);
        rdchk(TSS_OFF_STATUS, 32'h1, 32'h1);
        chk(gate_current_step, 32'h3);
        chk(irq, 32'h0);
        wr(TSS_OFF_MASK, 32'h1);
        cyc(2);
        chk(irq, 32'h1);
        temp_c <= 8'h5A;
        cyc(6);
        rdchk(TSS_OFF_STATUS, 32'h1, 32'h0);
        chk(gate_current_step, 32'h2);
        wr(TSS_OFF_IRQ, 32'h1);
        cyc(2);
        chk(irq, 32'h0);
        for (int sel = 0; sel < 2; sel++) begin
            wr(TSS_OFF_CTRL, 32'h0000_0030 | sel);
            temp_c <= 8'h8C;
            cyc(6);
            chk(driver_enable, 32'(sel == 0));
            rdchk(TSS_OFF_STATUS, 32'h2, 32'(sel) << 1);
            temp_c <= 8'h73;
            cyc(6);
        end
        wr(TSS_OFF_CTRL, 32'h0000_0030);
        wr(TSS_OFF_IRQ, 32'hF);
        wr(TSS_OFF_MASK, 32'h3);
        temp_c <= 8'h9B;
        cyc(6);
        chk(driver_enable, 32'h0);
        rdchk(TSS_OFF_IRQ, 32'h3, 32'h2);
        temp_c <= 8'h7D;
        cyc(8);
        chk(driver_enable, 32'h0);
        temp_c <= 8'h73;
        cyc(8);
        chk(driver_enable, 32'h1);
        wr(TSS_OFF_IRQ, 32'h3);
        cyc(2);
        chk(irq, 32'h0);
        wr(TSS_OFF_CTRL, 32'h0000_0A20);
        rdchk(TSS_OFF_STATUS, 32'h1F00, 32'h0500);
        undervoltage_b <= 1'b0;
        high_side_short <= 1'b1;
        wr(TSS_OFF_CTRL, 32'h0000_0A20);
        cyc(1);
        chk({driver_enable, high_side_short_off}, 32'h1);
        undervoltage_b <= 1'b1;
        high_side_short <= 1'b0;
        cyc(2);
        rdchk(TSS_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
        rdchk(TSS_OFF_STATUS, 32'h1F00, 32'h0);
        step_pulse <= 1'b1;
        cyc(1);
        step_pulse <= 1'b0;
        cyc(4);
        rdchk(TSS_OFF_STATUS, 32'h4, 32'h0);
        cyc(40);
        rdchk(TSS_OFF_STATUS, 32'h4, 32'h4);
        ext_run <= 1'b1;
        cyc(12);
        chk(ext_clk_selected, 32'h1);
        rdchk(TSS_OFF_STATUS, 32'h8, 32'h8);
        wr(TSS_OFF_CTRL, 32'h0000_0020);
        driver_disable_pin <= 1'b1;
        ext_run <= 1'b0;
        cyc(70);
        wr(TSS_OFF_CTRL, 32'h0000_0021);
        ext_run <= 1'b1;
        cyc(12);
        rdchk(TSS_OFF_CTRL, 32'h3FFF, 32'h0020);
        wr(TSS_OFF_CTRL, 32'h0000_0024);
        wr(TSS_OFF_MASK, 32'h8);
        ext_run <= 1'b0;
        cyc(30);
        chk(ext_clk_selected, 32'h1);
        cyc(40);
        chk({ext_clk_selected, irq}, 32'h1);
        rdchk(TSS_OFF_STATUS, 32'h10, 32'h10);
        wr(TSS_OFF_IRQ, 32'h8);
        cyc(2);
        chk(irq, 32'h0);
        complete_run();
    end
endmodule
